// ### core/tpc_pkg.sv
// Purpose: Shared constants and types for the timer capture/compare/PWM block.
// Assumes: Byte-wide register port, one clock, asynchronous active-low reset.
// Notes: Every offset and field position, and each multi-bit reset value, used by the block lives here.

package tpc_pkg;

	// Register port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Global register offsets.
	localparam logic [7:0] TSC_OFF = 8'h00;
	localparam logic [7:0] CNT_HI_OFF = 8'h01;
	localparam logic [7:0] CNT_LO_OFF = 8'h02;
	localparam logic [7:0] MOD_HI_OFF = 8'h03;
	localparam logic [7:0] MOD_LO_OFF = 8'h04;

	// Channel register layout: base plus stride per channel, then the byte within it.
	localparam logic [7:0] CH_BASE_OFF = 8'h05;
	localparam logic [7:0] CH_STRIDE = 8'h03;
	localparam logic [7:0] CH_CSC_SUB = 8'h00;
	localparam logic [7:0] CH_VHI_SUB = 8'h01;
	localparam logic [7:0] CH_VLO_SUB = 8'h02;

	// Field positions in the timer control/status byte.
	localparam int TSC_FLAG_BIT = 7;
	localparam int TSC_IE_BIT = 6;
	localparam int TSC_CAS_BIT = 5;
	localparam int TSC_RUN_BIT = 0;

	// Field positions in the channel control/status byte.
	localparam int CSC_FLAG_BIT = 7;
	localparam int CSC_IE_BIT = 6;
	localparam int CSC_MHI_BIT = 5;
	localparam int CSC_MLO_BIT = 4;
	localparam int CSC_ELHI_BIT = 3;
	localparam int CSC_ELLO_BIT = 2;

	// Edge/level codes: capture edges and compare pin actions share the encoding.
	localparam logic [1:0] EL_OFF = 2'h0;
	localparam logic [1:0] EL_TOGGLE = 2'h1;
	localparam logic [1:0] EL_CLEAR = 2'h2;
	localparam logic [1:0] EL_SET = 2'h3;

	// Counter and value constants.
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_FULL = 16'hffff;
	localparam logic [15:0] VAL_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Channel operating modes, one-hot.
	typedef enum logic [3:0] {
		MODE_CAPTURE = 4'b0001,
		MODE_COMPARE = 4'b0010,
		MODE_EDGE_PWM = 4'b0100,
		MODE_CENTER_PWM = 4'b1000
	} tpc_mode_t;

endpackage

// ### core/tpc_timer.sv
// Purpose: 16-bit timer with per-channel capture, compare, edge and center PWM.
// Assumes: Pins and register strobes are synchronous to clock; counter advances each clock while running.
// Notes: Byte-wide registers with write buffering and read latching for 16-bit coherency.

`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] With center select clear, each channel's mode bits pick capture, compare or edge PWM.
// [R2] Capture copies the counter into the channel value on the chosen pin edge.
// [R3] In capture, reading either value byte latches both until the other byte is read.
// [R4] Writing channel control/status drops partial value writes and resets byte sequencing.
// [R5] Each capture event sets the channel event flag.
// [R6] In compare, a counter match sets, clears or toggles the pin per edge/level bits.
// [R7] Compare action codes: 01 toggle, 10 clear, 11 set.
// [R8] Compare value loads from buffers only after both bytes are written.
// [R9] Compare and PWM channels set the event flag on every counter match.
// [R10] Edge PWM uses plain up-counting beside capture and compare channels.
// [R11] Edge PWM period comes from the modulus, width from overflow to match.
// [R12] Edge PWM polarity 0: overflow drives high, match low; polarity 1 inverts.
// [R13] Edge PWM value zero gives 0% duty; value above nonzero modulus gives 100%.
// [R14] Edge PWM duty loads when both bytes written and counter is zero.
// [R15] Center PWM counts up to modulus, down to zero; period and width doubled.
// [R16] Software keeps center-mode modulus in 0x0001..0x7FFF and never zero.
// [R17] Center PWM value zero or negative gives 0%; above nonzero modulus gives 100%.
// [R18] Center PWM polarity 0: up-count match drives low, down-count match drives high.
// [R19] Center PWM polarity 1 inverts, giving low-true pulses.
// [R20] Center mode modulus and value buffers load together at the turn-around.
// [R21] Writing timer control/status drops partial modulus writes and resets sequencing.
// [R22] Overflow flag sets at wrap to zero, or at turn-down from modulus.
// [R23] Overflow and per-channel interrupts are levels of flag and enable.
// [R24] Flags clear by read-while-set then write 0; a new event keeps them set.
module tpc_timer
	import tpc_pkg::*;
#(
	parameter int NUM_CH = 2
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [NUM_CH-1:0] ch_pin_in,
	output logic [NUM_CH-1:0] ch_pin_out,
	output logic [NUM_CH-1:0] ch_pin_oe,
	output logic overflow_irq,
	output logic [NUM_CH-1:0] channel_irq
);

	logic [15:0] cnt_reg;
	logic dir_up_reg;
	logic [15:0] mod_reg;
	logic [15:0] mod_buf_reg;
	logic mod_hi_wr_reg;
	logic mod_lo_wr_reg;
	logic run_reg;
	logic center_align_select;
	logic overflow_irq_enable;
	logic counter_overflow_flag;
	logic ovf_armed_reg;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] ch_rd_byte [NUM_CH];
	logic [15:0] term_cnt;
	logic ovf_evt;
	logic tsc_wr;
	logic tsc_rd;
	logic cnt_wr;
	logic mod_load;

	// Global register strobes.
	assign tsc_wr = reg_wr && (reg_addr == TSC_OFF);
	assign tsc_rd = reg_rd && (reg_addr == TSC_OFF);
	assign cnt_wr = reg_wr && ((reg_addr == CNT_HI_OFF) || (reg_addr == CNT_LO_OFF));

	// A zero modulus means the up-counter runs the full 16-bit range.
	assign term_cnt = (mod_reg == CNT_ZERO) ? CNT_FULL : mod_reg;

	// Overflow event: wrap to zero when up-counting, turn-down at modulus when centered.
	always_comb begin
		if (!run_reg || cnt_wr) begin
			ovf_evt = 1'b0;
		end else if (center_align_select) begin
			ovf_evt = dir_up_reg && (mod_reg != CNT_ZERO) && (cnt_reg >= mod_reg); // [R22]
		end else begin
			ovf_evt = (cnt_reg == term_cnt); // [R22]
		end
	end

	// Timer control bits written by software steer the counter and the channels.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run_reg <= 1'b0;
			center_align_select <= 1'b0;
			overflow_irq_enable <= 1'b0;
		end else if (tsc_wr) begin
			run_reg <= reg_wdata[TSC_RUN_BIT];
			center_align_select <= reg_wdata[TSC_CAS_BIT];
			overflow_irq_enable <= reg_wdata[TSC_IE_BIT];
		end
	end

	// Main counter; writing either counter byte restarts it at zero going up.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= CNT_ZERO;
			dir_up_reg <= 1'b1;
		end else if (cnt_wr) begin
			cnt_reg <= CNT_ZERO;
			dir_up_reg <= 1'b1;
		end else if (run_reg) begin
			if (center_align_select) begin
				// A zero modulus has no turn-around match, so the counter parks there.
				if (dir_up_reg) begin
					if (mod_reg == CNT_ZERO) begin
						cnt_reg <= CNT_ZERO;
					end else if (cnt_reg >= mod_reg) begin
						cnt_reg <= cnt_reg - CNT_ONE; // [R15]
						dir_up_reg <= 1'b0;
					end else begin
						cnt_reg <= cnt_reg + CNT_ONE;
					end
				end else if (cnt_reg == CNT_ZERO) begin
					cnt_reg <= cnt_reg + CNT_ONE; // [R15]
					dir_up_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - CNT_ONE;
				end
			end else begin
				dir_up_reg <= 1'b1;
				cnt_reg <= (cnt_reg == term_cnt) ? CNT_ZERO : cnt_reg + CNT_ONE; // [R10]
			end
		end
	end

	// Modulus loads when both bytes are in; in center mode it waits for the turn-around.
	assign mod_load = mod_hi_wr_reg && mod_lo_wr_reg && (!center_align_select || ovf_evt); // [R20]

	// Modulus byte buffers and their coherency sequence.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mod_buf_reg <= VAL_RESET;
			mod_hi_wr_reg <= 1'b0;
			mod_lo_wr_reg <= 1'b0;
		end else if (tsc_wr) begin
			mod_hi_wr_reg <= 1'b0; // [R21]
			mod_lo_wr_reg <= 1'b0; // [R21]
		end else if (reg_wr && (reg_addr == MOD_HI_OFF)) begin
			mod_buf_reg[15:8] <= reg_wdata;
			mod_hi_wr_reg <= 1'b1;
		end else if (reg_wr && (reg_addr == MOD_LO_OFF)) begin
			mod_buf_reg[7:0] <= reg_wdata;
			mod_lo_wr_reg <= 1'b1;
		end else if (mod_load) begin
			mod_hi_wr_reg <= 1'b0;
			mod_lo_wr_reg <= 1'b0;
		end
	end

	// Active modulus that the counter compares against.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mod_reg <= VAL_RESET;
		end else if (mod_load) begin
			mod_reg <= mod_buf_reg; // [R11]
		end
	end

	// Overflow flag clear sequence; a new event disarms the pending clear so set wins.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			counter_overflow_flag <= 1'b0;
			ovf_armed_reg <= 1'b0;
		end else if (ovf_evt) begin
			counter_overflow_flag <= 1'b1; // [R22]
			ovf_armed_reg <= 1'b0; // [R24]
		end else if (tsc_rd && counter_overflow_flag) begin
			ovf_armed_reg <= 1'b1; // [R24]
		end else if (tsc_wr) begin
			if (ovf_armed_reg && !reg_wdata[TSC_FLAG_BIT]) begin
				counter_overflow_flag <= 1'b0; // [R24]
			end
			ovf_armed_reg <= 1'b0;
		end
	end

	assign overflow_irq = counter_overflow_flag && overflow_irq_enable; // [R23]

	// Per-channel logic.
	for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
		localparam logic [7:0] CSC_A = 8'(CH_BASE_OFF + CH_STRIDE * n + CH_CSC_SUB);
		localparam logic [7:0] VHI_A = 8'(CH_BASE_OFF + CH_STRIDE * n + CH_VHI_SUB);
		localparam logic [7:0] VLO_A = 8'(CH_BASE_OFF + CH_STRIDE * n + CH_VLO_SUB);
		logic [15:0] val_reg;
		logic [15:0] buf_reg;
		logic [15:0] latch_reg;
		logic [15:0] rd_src;
		logic vhi_wr_reg;
		logic vlo_wr_reg;
		logic latched_reg;
		logic first_hi_reg;
		logic flag_reg;
		logic armed_reg;
		logic channel_irq_enable;
		logic channel_mode_bit_hi;
		logic channel_mode_bit_lo;
		logic [1:0] el_reg;
		logic pin_prev_reg;
		logic out_reg;
		logic active_lvl;
		logic csc_wr;
		logic csc_rd;
		logic vhi_rd;
		logic vlo_rd;
		logic cap_evt;
		logic match;
		logic val_load;
		tpc_mode_t mode;

		assign csc_wr = reg_wr && (reg_addr == CSC_A);
		assign csc_rd = reg_rd && (reg_addr == CSC_A);
		assign vhi_rd = reg_rd && (reg_addr == VHI_A);
		assign vlo_rd = reg_rd && (reg_addr == VLO_A);

		// Center select overrides the per-channel mode bits.
		always_comb begin
			if (center_align_select) begin
				mode = MODE_CENTER_PWM;
			end else if (!channel_mode_bit_hi && !channel_mode_bit_lo) begin
				mode = MODE_CAPTURE; // [R1]
			end else if (!channel_mode_bit_hi) begin
				mode = MODE_COMPARE; // [R1]
			end else begin
				mode = MODE_EDGE_PWM; // [R1]
			end
		end

		// Bit 0 of the edge code picks rising edges, bit 1 falling edges.
		assign cap_evt = (mode == MODE_CAPTURE) &&
			((el_reg[0] && ch_pin_in[n] && !pin_prev_reg) ||
			(el_reg[1] && !ch_pin_in[n] && pin_prev_reg)); // [R2]
		assign match = run_reg && (mode != MODE_CAPTURE) && (cnt_reg == val_reg); // [R9]
		assign active_lvl = !el_reg[0]; // [R12] [R19]

		// Buffered value transfer point depends on the mode.
		always_comb begin
			case (mode)
				MODE_EDGE_PWM: val_load = vhi_wr_reg && vlo_wr_reg && (cnt_reg == CNT_ZERO); // [R14]
				MODE_CENTER_PWM: val_load = vhi_wr_reg && vlo_wr_reg && ovf_evt; // [R20]
				default: val_load = vhi_wr_reg && vlo_wr_reg; // [R8]
			endcase
		end

		// Channel control bits.
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				channel_irq_enable <= 1'b0;
				channel_mode_bit_hi <= 1'b0;
				channel_mode_bit_lo <= 1'b0;
				el_reg <= EL_OFF;
			end else if (csc_wr) begin
				channel_irq_enable <= reg_wdata[CSC_IE_BIT];
				channel_mode_bit_hi <= reg_wdata[CSC_MHI_BIT];
				channel_mode_bit_lo <= reg_wdata[CSC_MLO_BIT];
				el_reg <= reg_wdata[CSC_ELHI_BIT:CSC_ELLO_BIT];
			end
		end

		// Value byte buffers; a control write cancels a half-written value.
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				buf_reg <= VAL_RESET;
				vhi_wr_reg <= 1'b0;
				vlo_wr_reg <= 1'b0;
			end else if (csc_wr) begin
				vhi_wr_reg <= 1'b0; // [R4]
				vlo_wr_reg <= 1'b0; // [R4]
			end else if (reg_wr && (reg_addr == VHI_A)) begin
				buf_reg[15:8] <= reg_wdata;
				vhi_wr_reg <= 1'b1;
			end else if (reg_wr && (reg_addr == VLO_A)) begin
				buf_reg[7:0] <= reg_wdata;
				vlo_wr_reg <= 1'b1;
			end else if (val_load) begin
				vhi_wr_reg <= 1'b0;
				vlo_wr_reg <= 1'b0;
			end
		end

		// Active channel value; a capture takes precedence over a buffered load.
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				val_reg <= VAL_RESET;
			end else if (cap_evt) begin
				val_reg <= cnt_reg; // [R2]
			end else if (val_load) begin
				val_reg <= buf_reg; // [R8]
			end
		end

		// Read latch so the second byte read matches the first in capture mode.
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				latch_reg <= VAL_RESET;
				latched_reg <= 1'b0;
				first_hi_reg <= 1'b0;
			end else if (csc_wr) begin
				latched_reg <= 1'b0; // [R4]
			end else if ((vhi_rd || vlo_rd) && (mode == MODE_CAPTURE)) begin
				if (!latched_reg) begin
					latch_reg <= val_reg; // [R3]
					latched_reg <= 1'b1;
					first_hi_reg <= vhi_rd;
				end else if (vhi_rd != first_hi_reg) begin
					latched_reg <= 1'b0; // [R3]
				end
			end
		end

		// Channel event flag with the two-step clear; an event disarms the clear.
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				flag_reg <= 1'b0;
				armed_reg <= 1'b0;
			end else if (cap_evt || match) begin
				flag_reg <= 1'b1; // [R5] [R9]
				armed_reg <= 1'b0; // [R24]
			end else if (csc_rd && flag_reg) begin
				armed_reg <= 1'b1; // [R24]
			end else if (csc_wr) begin
				if (armed_reg && !reg_wdata[CSC_FLAG_BIT]) begin
					flag_reg <= 1'b0; // [R24]
				end
				armed_reg <= 1'b0;
			end
		end

		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				pin_prev_reg <= 1'b0;
			end else begin
				pin_prev_reg <= ch_pin_in[n];
			end
		end

		// Pin output state per mode; match is checked before overflow so zero duty wins.
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				out_reg <= 1'b0;
			end else begin
				case (mode)
					MODE_COMPARE: begin
						if (match) begin
							case (el_reg)
								EL_TOGGLE: out_reg <= !out_reg; // [R6] [R7]
								EL_CLEAR: out_reg <= 1'b0; // [R7]
								EL_SET: out_reg <= 1'b1; // [R7]
								default: out_reg <= out_reg;
							endcase
						end
					end
					MODE_EDGE_PWM: begin
						if (match) begin
							out_reg <= !active_lvl; // [R11] [R12] [R13]
						end else if (run_reg && (cnt_reg == CNT_ZERO)) begin
							out_reg <= active_lvl; // [R11] [R12]
						end
					end
					MODE_CENTER_PWM: begin
						if ((val_reg == VAL_RESET) || val_reg[15]) begin
							out_reg <= !active_lvl; // [R17]
						end else if (val_reg > mod_reg) begin
							out_reg <= active_lvl; // [R17]
						end else if (match) begin
							out_reg <= dir_up_reg ? !active_lvl : active_lvl; // [R18] [R19]
						end
					end
					default: out_reg <= out_reg;
				endcase
			end
		end

		assign ch_pin_out[n] = out_reg;
		assign ch_pin_oe[n] = (mode != MODE_CAPTURE) && (el_reg != EL_OFF);
		assign channel_irq[n] = flag_reg && channel_irq_enable; // [R23]

		// Readback; capture mode shows the latched word once a byte has been read.
		assign rd_src = ((mode == MODE_CAPTURE) && latched_reg) ? latch_reg : val_reg; // [R3]
		always_comb begin
			if (reg_addr == CSC_A) begin
				ch_rd_byte[n] = {flag_reg, channel_irq_enable, channel_mode_bit_hi,
					channel_mode_bit_lo, el_reg, 2'h0};
			end else if (reg_addr == VHI_A) begin
				ch_rd_byte[n] = rd_src[15:8];
			end else if (reg_addr == VLO_A) begin
				ch_rd_byte[n] = rd_src[7:0];
			end else begin
				ch_rd_byte[n] = BYTE_ZERO;
			end
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		case (reg_addr)
			TSC_OFF: rd_mux = {counter_overflow_flag, overflow_irq_enable,
				center_align_select, 4'h0, run_reg};
			CNT_HI_OFF: rd_mux = cnt_reg[15:8];
			CNT_LO_OFF: rd_mux = cnt_reg[7:0];
			MOD_HI_OFF: rd_mux = mod_reg[15:8];
			MOD_LO_OFF: rd_mux = mod_reg[7:0];
			default: rd_mux = BYTE_ZERO;
		endcase
		for (int i = 0; i < NUM_CH; i++) begin
			rd_mux = rd_mux | ch_rd_byte[i];
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_reg <= BYTE_ZERO;
		end else begin
			rd_data_reg <= reg_rd ? rd_mux : BYTE_ZERO;
		end
	end

	assign reg_rdata = rd_data_reg;

endmodule

`default_nettype wire

// ### bench/tpc_pin_env.sv
// Purpose: Far-side model of the channel pins: event sources and loads.
// Assumes: Sources change just after a rising clock edge, driven by the bench.
// Notes: A pin the device drives carries the device's level, else the source's.

`timescale 1ns/1ps
`default_nettype none

module tpc_pin_env #(
	parameter int NUM_CH = 2
) (
	input wire logic [NUM_CH-1:0] src_level,
	input wire logic [NUM_CH-1:0] ch_pin_out,
	input wire logic [NUM_CH-1:0] ch_pin_oe,
	output logic [NUM_CH-1:0] ch_pin_in
);
	// Resolve each wire so a capture channel never sees its own stale drive.
	assign ch_pin_in = (ch_pin_oe & ch_pin_out) | (~ch_pin_oe & src_level);
endmodule

`default_nettype wire

// ### bench/tpc_timer_props.sv
// Purpose: Port-level checks of the timer channel block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Channel checks watch channel 0 only, to keep the antecedents reachable.

`timescale 1ns/1ps
`default_nettype none

module tpc_timer_chk
	import tpc_pkg::*;
#(
	parameter int NUM_CH = 2
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic [NUM_CH-1:0] ch_pin_in,
	input wire logic [NUM_CH-1:0] ch_pin_out,
	input wire logic [NUM_CH-1:0] ch_pin_oe,
	input wire logic overflow_irq,
	input wire logic [NUM_CH-1:0] channel_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic tsc_wr;
	logic csc_wr;

	// Control writes are the only way a flag or enable can drop.
	assign tsc_wr = reg_wr && reg_addr == TSC_OFF;
	assign csc_wr = reg_wr && reg_addr == CH_BASE_OFF;

	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_ovf_ie_off; tsc_wr && !reg_wdata[TSC_IE_BIT] |=> !overflow_irq; endproperty
	a_ovf_ie_off: assert property (p_ovf_ie_off) else $error("overflow irq not masked");
	property p_ch_ie_off; csc_wr && !reg_wdata[CSC_IE_BIT] |=> !channel_irq[0]; endproperty
	a_ch_ie_off: assert property (p_ch_ie_off) else $error("channel irq not masked");
	property p_ovf_fall; $fell(overflow_irq) |-> $past(tsc_wr); endproperty
	a_ovf_fall: assert property (p_ovf_fall) else $error("overflow irq dropped alone");
	property p_ch_fall; $fell(channel_irq[0]) |-> $past(csc_wr); endproperty
	a_ch_fall: assert property (p_ch_fall) else $error("channel irq dropped alone");
	property p_oe_off;
		csc_wr && reg_wdata[CSC_ELHI_BIT:CSC_ELLO_BIT] == EL_OFF |=> !ch_pin_oe[0];
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven with action off");
	property p_ovf_rd; reg_rd && reg_addr == TSC_OFF && overflow_irq |=> reg_rdata[7:6] == 2'h3;
	endproperty
	a_ovf_rd: assert property (p_ovf_rd) else $error("overflow irq without flag");
	property p_ch_rd;
		reg_rd && reg_addr == CH_BASE_OFF && channel_irq[0] |=> reg_rdata[7:6] == 2'h3;
	endproperty
	a_ch_rd: assert property (p_ch_rd) else $error("channel irq without flag");
endmodule

bind tpc_timer tpc_timer_chk #(.NUM_CH(NUM_CH)) chk_i (.clock(clock), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
	.ch_pin_oe(ch_pin_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq));

`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the timer capture, compare and PWM block.
// Assumes: Byte register port with read data one cycle after the strobe.
// Notes: Capture times are judged by cycle distance, since the counter phase is free.

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import tpc_pkg::*;
	localparam int NCH = 2;
	localparam logic [7:0] C0 = CH_BASE_OFF;
	localparam logic [7:0] C0H = CH_BASE_OFF + CH_VHI_SUB;
	localparam logic [7:0] C0L = CH_BASE_OFF + CH_VLO_SUB;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [NCH-1:0] src_level = 2'h0;
	logic [7:0] reg_rdata;
	logic [NCH-1:0] ch_pin_in, ch_pin_out, ch_pin_oe, channel_irq;
	logic overflow_irq;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [31:0] rng = 32'hc1af510f;

	tpc_timer #(.NUM_CH(NCH)) DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
		.overflow_irq(overflow_irq), .channel_irq(channel_irq));
	tpc_pin_env #(.NUM_CH(NCH)) ENV (.src_level(src_level), .ch_pin_out(ch_pin_out),
		.ch_pin_oe(ch_pin_oe), .ch_pin_in(ch_pin_in));

	// Clock and a free cycle count used to time capture events.
	always #2 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// Read data is taken just after the edge that follows the strobe, its only cycle.
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task rd16(input logic [7:0] hi, output logic [15:0] v);
		logic [7:0] a, b;
		rd(hi, a);
		rd(hi + 8'h01, b);
		v = {a, b};
	endtask

	task pulse(input int ch, output int t);
		@(posedge clock);
		src_level[ch] <= 1'b1;
		t = cyc;
		@(posedge clock);
		src_level[ch] <= 1'b0;
	endtask

	// A half-written pair must be dropped by the control write, a whole pair kept.
	task coh(input logic [7:0] hi, input logic [7:0] ctl, input logic [7:0] cv,
		input logic [15:0] nv, input logic [15:0] ov);
		logic [15:0] v;
		wr(hi, nv[15:8]);
		wr(ctl, cv);
		wr(hi + 8'h01, nv[7:0]);
		tick(2);
		rd16(hi, v);
		chk("partial_pair", ov, v);
		wr(hi, nv[15:8]);
		tick(2);
		rd16(hi, v);
		chk("whole_pair", nv, v);
	endtask

	// Load a duty value, then count active cycles over two periods.
	// Two periods are let pass first: the one right after the load may still be partial.
	task pwm(input logic [1:0] el, input logic [15:0] dv, input int per, input int e);
		int k;
		wr(C0, {4'h2, el, 2'h0});
		wr(C0H, dv[15:8]);
		wr(C0L, dv[7:0]);
		tick(2 * per + 4);
		k = 0;
		repeat (2 * per) begin
			@(posedge clock);
			#1 if (ch_pin_out[0] === ~el[0]) k++;
		end
		chk("pwm_active", e, k);
	endtask

	task conclude();
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// A hang counts as a mismatch; the span is well beyond the few thousand cycles used.
	initial begin
		tick(100000);
		n_mismatch++;
		conclude();
	end

	initial begin
		int t0, t1, t2, m, d;
		logic [7:0] b, b2;
		logic [15:0] v1, v2, v3;
		logic [1:0] codes [3];
		logic ex [3];
		codes = '{EL_SET, EL_CLEAR, EL_TOGGLE};
		ex = '{1'b1, 1'b0, 1'b1};
		tick(3);
		rst_n <= 1'b1;
		rd(TSC_OFF, b);
		chk("tsc_reset", 8'h00, b);
		rd(C0, b);
		chk("csc_reset", 8'h00, b);
		wr(C0, 8'h44);
		wr(TSC_OFF, 8'h01);
		pulse(0, t0);
		tick(2);
		chk("cap_irq", 1'b1, channel_irq[0]);
		rd16(C0H, v1);
		tick(3 + xs() % 60);
		pulse(0, t1);
		tick(2);
		rd(C0H, b);
		tick(xs() % 20);
		pulse(0, t2);
		tick(2);
		rd(C0L, b2);
		v2 = {b, b2};
		chk("cap_gap", 16'(t1 - t0), 16'(v2 - v1));
		rd16(C0H, v3);
		chk("cap_latch", 16'(t2 - t1), 16'(v3 - v2));
		rd(C0, b);
		pulse(0, t0);
		wr(C0, 8'h44);
		rd(C0, b);
		chk("flag_kept", 1'b1, b[7]);
		wr(C0, 8'h44);
		rd(C0, b);
		chk("flag_clear", 1'b0, b[7]);
		chk("irq_clear", 1'b0, channel_irq[0]);
		// The counter restarts before the new value lands, so no early match can toggle the pin.
		for (int i = 0; i < 3; i++) begin
			m = 16 + xs() % 200;
			rd(C0, b);
			wr(C0, {4'h1, codes[i], 2'h0});
			wr(CNT_HI_OFF, 8'h00);
			wr(C0H, m[15:8]);
			wr(C0L, m[7:0]);
			tick(m + 4);
			chk("cmp_pin", ex[i], ch_pin_out[0]);
			chk("cmp_oe", 1'b1, ch_pin_oe[0]);
			rd(C0, b);
			chk("cmp_flag", 1'b1, b[7]);
		end
		coh(C0H, C0, {4'h1, EL_OFF, 2'h0}, 16'h2345, 16'(m));
		coh(MOD_HI_OFF, TSC_OFF, 8'h01, 16'h0030, 16'h0000);
		wr(CNT_HI_OFF, 8'h00);
		wr(CH_BASE_OFF + CH_STRIDE, 8'h4c);
		d = 1 + xs() % 47;
		pwm(EL_CLEAR, 16'(d), 49, 2 * d);
		pwm(EL_TOGGLE, 16'(d), 49, 2 * d);
		pwm(EL_CLEAR, 16'h0000, 49, 0);
		pwm(EL_CLEAR, 16'h003c, 49, 98);
		rd(TSC_OFF, b);
		chk("ovf_up", 1'b1, b[7]);
		pulse(1, t0);
		tick(2);
		chk("side_capture", 1'b1, channel_irq[1]);
		wr(TSC_OFF, 8'h61);
		pwm(EL_CLEAR, 16'(d), 96, 4 * d);
		pwm(EL_TOGGLE, 16'(d), 96, 4 * d);
		pwm(EL_CLEAR, 16'h0000, 96, 0);
		pwm(EL_CLEAR, 16'h8005, 96, 0);
		pwm(EL_CLEAR, 16'h003c, 96, 192);
		chk("ovf_irq", 1'b1, overflow_irq);
		// Stop the counter so no new overflow can slip into the clear sequence.
		wr(TSC_OFF, 8'h60);
		rd(TSC_OFF, b);
		chk("ovf_kept", 1'b1, b[7]);
		wr(TSC_OFF, 8'h60);
		rd(TSC_OFF, b);
		chk("ovf_clear", 1'b0, b[7]);
		chk("ovf_irq_clear", 1'b0, overflow_irq);
		conclude();
	end
endmodule

`default_nettype wire
